// File: fpds_drive.sv
module fpds_drive #(
	parameter logic [fpds_pkg::CNT_W-1:0] HF_SLOW_CYC = fpds_pkg::HF_SLOW_CYC,
	parameter logic [fpds_pkg::CNT_W-1:0] LF_CYC [8] = fpds_pkg::LF_CYC_TAB,
	parameter logic [fpds_pkg::CNT_W-1:0] STRETCH_CYC = fpds_pkg::STRETCH_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	// Duty settings, eight bits per channel, channel one lowest.
	input wire logic [31:0] duty,
	// Full-speed pin and its function select.
	input wire logic full_speed_en,
	input wire logic full_speed_n,
	// Fan side.
	output logic [3:0] pwm_out,
	input wire logic [3:0] tach_in,
	output logic [3:0] tach_level,
	output logic [3:0] tach_edge
);
	localparam int W = fpds_pkg::CNT_W;

	initial begin
		if (HF_SLOW_CYC < 24'h000002 || STRETCH_CYC == 24'h000000) begin
			$error("fpds_drive: period and stretch counts must be nonzero");
		end
	end

	//==================================================================
	// Registers.
	logic [7:0] cfg_one_q, pair_a_q, pair_b_q, cfg_two_q, rdata_q;
	wire wr_one = reg_wr && reg_addr == fpds_pkg::ADDR_DRIVE_CONFIG_ONE;
	wire wr_a = reg_wr && reg_addr == fpds_pkg::ADDR_PWM_PAIR_A_CONFIG;
	wire wr_b = reg_wr && reg_addr == fpds_pkg::ADDR_PWM_PAIR_B_CONFIG;
	wire wr_two = reg_wr && reg_addr == fpds_pkg::ADDR_DRIVE_CONFIG_TWO;
	wire [7:0] rd_mux = reg_addr == fpds_pkg::ADDR_DRIVE_CONFIG_ONE ? cfg_one_q :
		reg_addr == fpds_pkg::ADDR_PWM_PAIR_A_CONFIG ? pair_a_q :
		reg_addr == fpds_pkg::ADDR_PWM_PAIR_B_CONFIG ? pair_b_q :
		reg_addr == fpds_pkg::ADDR_DRIVE_CONFIG_TWO ? cfg_two_q : fpds_pkg::UNMAPPED_READ;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_one_q <= fpds_pkg::RST_DRIVE_CONFIG_ONE;
			pair_a_q <= fpds_pkg::RST_PWM_PAIR_CONFIG;
			pair_b_q <= fpds_pkg::RST_PWM_PAIR_CONFIG;
			cfg_two_q <= fpds_pkg::RST_DRIVE_CONFIG_TWO;
			rdata_q <= 8'h00;
		end else begin
			if (wr_one) cfg_one_q <= reg_wdata;
			if (wr_a) pair_a_q <= reg_wdata;
			if (wr_b) pair_b_q <= reg_wdata;
			if (wr_two) cfg_two_q <= reg_wdata;
			rdata_q <= rd_mux;
		end
	end
	assign reg_rdata = rdata_q;

	//==================================================================
	// Shared frequency selection and period counter.
	wire lf_mode = cfg_one_q[fpds_pkg::MODE_BIT];
	wire [2:0] freq_code = cfg_two_q[fpds_pkg::FREQ_MSB:fpds_pkg::FREQ_LSB];
	wire [W-1:0] hf_period = freq_code == 3'h0 ? HF_SLOW_CYC : fpds_pkg::HF_FAST_CYC;
	wire [W-1:0] period = lf_mode ? LF_CYC[freq_code] : hf_period;
	wire [W-1:0] period_last = period - 24'h000001;
	logic [W-1:0] cnt_q;

	// One counter serves all channels, so they can never drift apart.
	always_ff @(posedge clk) begin
		if (sys_rst || cnt_q >= period_last) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 24'h000001;
		end
	end

	//==================================================================
	// Full-speed synchroniser.
	logic fs_s1_q, fs_s2_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fs_s1_q <= 1'b1;
			fs_s2_q <= 1'b1;
		end else begin
			fs_s1_q <= full_speed_n;
			fs_s2_q <= fs_s1_q;
		end
	end
	wire fs_active = full_speed_en && !fs_s2_q;

	//==================================================================
	// Channels.
	wire [3:0] inv = {pair_b_q[fpds_pkg::INV_SECOND_BIT], pair_b_q[fpds_pkg::INV_FIRST_BIT],
		pair_a_q[fpds_pkg::INV_SECOND_BIT], pair_a_q[fpds_pkg::INV_FIRST_BIT]};
	wire [W-1:0] stretch_lim = STRETCH_CYC < period ? STRETCH_CYC : period;
	logic [3:0] raw;
	logic [3:0] pwm_q;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			wire [7:0] d = duty[8*g +: 8];
			wire [31:0] prod = 32'(d) * 32'(period);
			wire [W-1:0] on_prog = d == 8'hFF ? period : prod[31:8];
			// A short nonzero pulse is widened in low-frequency mode only.
			wire stretch = lf_mode && d != 8'h00 && on_prog < stretch_lim;
			wire [W-1:0] on_eff = stretch ? stretch_lim : on_prog;
			assign raw[g] = cnt_q < on_eff;
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					pwm_q[g] <= 1'b0;
				end else begin
					pwm_q[g] <= fs_active ? 1'b1 : raw[g] ^ inv[g];
				end
			end
		end
	endgenerate
	assign pwm_out = pwm_q;

	//==================================================================
	// Tach conditioning: two-flop sync, then a level must hold for the filter time.
	logic [3:0] t_s1_q, t_s2_q, t_lvl_q, t_lvl_out_q, t_edge_q;
	logic [7:0] t_cnt_q [4];
	wire [3:0] tach_dis = cfg_two_q[3:0];

	generate
		for (g = 0; g < 4; g++) begin : g_tach
			wire differ = t_s2_q[g] != t_lvl_q[g];
			wire settle = differ && t_cnt_q[g] >= fpds_pkg::TACH_FILT_CYC - 8'h01;
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					// Tach pins idle high on their pull-ups, so starting high avoids a false edge after reset.
					t_s1_q[g] <= 1'b1;
					t_s2_q[g] <= 1'b1;
					t_lvl_q[g] <= 1'b1;
					t_cnt_q[g] <= 8'h00;
					t_lvl_out_q[g] <= 1'b0;
					t_edge_q[g] <= 1'b0;
				end else begin
					t_s1_q[g] <= tach_in[g];
					t_s2_q[g] <= t_s1_q[g];
					t_cnt_q[g] <= differ && !settle ? t_cnt_q[g] + 8'h01 : 8'h00;
					if (settle) t_lvl_q[g] <= t_s2_q[g];
					t_lvl_out_q[g] <= !tach_dis[g] && (settle ? t_s2_q[g] : t_lvl_q[g]);
					t_edge_q[g] <= !tach_dis[g] && settle && t_s2_q[g];
				end
			end
		end
	endgenerate
	assign tach_level = t_lvl_out_q;
	assign tach_edge = t_edge_q;

	//==================================================================
	// Assertions.
	property p_cfg_two_write;
		@(posedge clk) disable iff (sys_rst) wr_two |=> cfg_two_q == $past(reg_wdata);
	endproperty
	a_cfg_two_write: assert property (p_cfg_two_write) else $error("frequency register missed a write");

	property p_hf_period;
		@(posedge clk) disable iff (sys_rst)
		!lf_mode |-> period == (freq_code == 3'h0 ? HF_SLOW_CYC : fpds_pkg::HF_FAST_CYC);
	endproperty
	a_hf_period: assert property (p_hf_period) else $error("wrong high-frequency period");

	property p_lf_wrap;
		@(posedge clk) disable iff (sys_rst)
		lf_mode && $stable(cfg_two_q) && cnt_q == LF_CYC[freq_code] - 24'h000001 |=> cnt_q == '0;
	endproperty
	a_lf_wrap: assert property (p_lf_wrap) else $error("low-frequency period wrong");

	property p_invert;
		@(posedge clk) disable iff (sys_rst)
		!fs_active && inv[0] |=> pwm_q[0] == !$past(raw[0]);
	endproperty
	a_invert: assert property (p_invert) else $error("inverted channel not complemented");

	property p_inv_reset;
		@(posedge clk) sys_rst |=> pair_a_q[5:4] == 2'b00 && pair_b_q[5:4] == 2'b00;
	endproperty
	a_inv_reset: assert property (p_inv_reset) else $error("inversion bits not cleared by reset");

	property p_full_speed;
		@(posedge clk) disable iff (sys_rst) full_speed_en && !full_speed_n [*3] |=> pwm_q == 4'hF;
	endproperty
	a_full_speed: assert property (p_full_speed) else $error("full-speed did not force outputs high");

	property p_stretch;
		@(posedge clk) disable iff (sys_rst)
		lf_mode && !fs_active && !inv[0] && duty[7:0] != 8'h00 && cnt_q < stretch_lim |=> pwm_q[0];
	endproperty
	a_stretch: assert property (p_stretch) else $error("low-frequency pulse not stretched");

	property p_no_stretch;
		@(posedge clk) disable iff (sys_rst)
		!lf_mode && !fs_active && !inv[0] && duty[7:0] == 8'h00 |=> !pwm_q[0];
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("high-frequency pulse altered");

	property p_tach_dis;
		@(posedge clk) disable iff (sys_rst) tach_dis[0] |=> !tach_edge[0] && !tach_level[0];
	endproperty
	a_tach_dis: assert property (p_tach_dis) else $error("disabled tach still reported");

	property p_tach_single;
		@(posedge clk) disable iff (sys_rst) tach_edge[0] |=> !tach_edge[0];
	endproperty
	a_tach_single: assert property (p_tach_single) else $error("tach edge longer than one cycle");

	property p_cfg_one_write;
		@(posedge clk) disable iff (sys_rst)
		wr_one |=> cfg_one_q == $past(reg_wdata);
	endproperty
	a_cfg_one_write: assert property (p_cfg_one_write) else $error("mode register missed a write");

	property p_pair_a_write;
		@(posedge clk) disable iff (sys_rst)
		wr_a |=> pair_a_q == $past(reg_wdata);
	endproperty
	a_pair_a_write: assert property (p_pair_a_write) else $error("first pair register missed a write");

	property p_pair_b_write;
		@(posedge clk) disable iff (sys_rst)
		wr_b |=> pair_b_q == $past(reg_wdata);
	endproperty
	a_pair_b_write: assert property (p_pair_b_write) else $error("second pair register missed a write");

	property p_rd_unmapped;
		@(posedge clk) disable iff (sys_rst)
		reg_addr != 8'h40 && reg_addr != 8'h68 && reg_addr != 8'h69 && reg_addr != 8'h74 |=> reg_rdata == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

	property p_hf_fast;
		@(posedge clk) disable iff (sys_rst)
		!lf_mode && freq_code != 3'h0 |-> period == fpds_pkg::HF_FAST_CYC;
	endproperty
	a_hf_fast: assert property (p_hf_fast) else $error("fast high-frequency period wrong");

	property p_hf_slow;
		@(posedge clk) disable iff (sys_rst)
		!lf_mode && freq_code == 3'h0 |-> period == HF_SLOW_CYC;
	endproperty
	a_hf_slow: assert property (p_hf_slow) else $error("slow high-frequency period wrong");

	property p_cnt_range;
		@(posedge clk) disable iff (sys_rst)
		$stable(period) && cnt_q < period |=> cnt_q < period;
	endproperty
	a_cnt_range: assert property (p_cnt_range) else $error("period counter ran past its period");

	property p_invert_two;
		@(posedge clk) disable iff (sys_rst)
		!fs_active && inv[1] |=> pwm_q[1] == !$past(raw[1]);
	endproperty
	a_invert_two: assert property (p_invert_two) else $error("channel two not complemented");

	property p_invert_three;
		@(posedge clk) disable iff (sys_rst)
		!fs_active && inv[2] |=> pwm_q[2] == !$past(raw[2]);
	endproperty
	a_invert_three: assert property (p_invert_three) else $error("channel three not complemented");

	property p_invert_four;
		@(posedge clk) disable iff (sys_rst)
		!fs_active && inv[3] |=> pwm_q[3] == !$past(raw[3]);
	endproperty
	a_invert_four: assert property (p_invert_four) else $error("channel four not complemented");

	property p_no_invert;
		@(posedge clk) disable iff (sys_rst)
		!fs_active && !inv[0] |=> pwm_q[0] == $past(raw[0]);
	endproperty
	a_no_invert: assert property (p_no_invert) else $error("plain channel altered");

	property p_fs_gate;
		@(posedge clk) disable iff (sys_rst)
		!full_speed_en |=> pwm_q == $past(raw ^ inv);
	endproperty
	a_fs_gate: assert property (p_fs_gate) else $error("override active while function off");

	property p_tach_dis_all;
		@(posedge clk) disable iff (sys_rst)
		tach_dis != 4'h0 |=> ((tach_edge | tach_level) & $past(tach_dis)) == 4'h0;
	endproperty
	a_tach_dis_all: assert property (p_tach_dis_all) else $error("disabled tach channel reported");

	property p_tach_edge_level;
		@(posedge clk) disable iff (sys_rst)
		tach_edge[0] |-> tach_level[0];
	endproperty
	a_tach_edge_level: assert property (p_tach_edge_level) else $error("tach edge without high level");

	property p_tach_single_all;
		@(posedge clk) disable iff (sys_rst)
		tach_edge != 4'h0 |=> (tach_edge & $past(tach_edge)) == 4'h0;
	endproperty
	a_tach_single_all: assert property (p_tach_single_all) else $error("tach edge repeated");

	property p_tach_glitch;
		@(posedge clk) disable iff (sys_rst)
		t_s2_q[0] != t_lvl_q[0] && t_cnt_q[0] < fpds_pkg::TACH_FILT_CYC - 8'h01 |=> $stable(t_lvl_q[0]);
	endproperty
	a_tach_glitch: assert property (p_tach_glitch) else $error("short tach pulse passed the filter");

	property p_mode_reset;
		@(posedge clk)
		sys_rst |=> !lf_mode && cfg_two_q == fpds_pkg::RST_DRIVE_CONFIG_TWO;
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode or frequency not reset");

endmodule

// File: fpds_pkg.sv
//======================================================================
package fpds_pkg;

	//==================================================================
	// Register map.
	localparam logic [7:0] ADDR_DRIVE_CONFIG_ONE = 8'h40;
	localparam logic [7:0] ADDR_PWM_PAIR_A_CONFIG = 8'h68;
	localparam logic [7:0] ADDR_PWM_PAIR_B_CONFIG = 8'h69;
	localparam logic [7:0] ADDR_DRIVE_CONFIG_TWO = 8'h74;
	localparam logic [7:0] RST_DRIVE_CONFIG_ONE = 8'h00;
	localparam logic [7:0] RST_PWM_PAIR_CONFIG = 8'h00;
	localparam logic [7:0] RST_DRIVE_CONFIG_TWO = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	//==================================================================
	// Field positions.
	localparam int MODE_BIT = 6;
	localparam int FREQ_LSB = 4;
	localparam int FREQ_MSB = 6;
	localparam int INV_FIRST_BIT = 5;
	localparam int INV_SECOND_BIT = 4;

	//==================================================================
	// Timing, frequencies in millihertz.
	localparam longint CLK_HZ = 25_000_000;
	localparam longint HF_SLOW_MHZ = 1_400_000;
	localparam longint HF_FAST_MHZ = 22_500_000;
	localparam longint STRETCH_MIN_MS = 10;
	localparam longint TACH_FILT_NS = 1000;
	localparam int CNT_W = 24;

	function automatic logic [CNT_W-1:0] fpds_cyc(input longint mhz);
		fpds_cyc = CNT_W'((CLK_HZ * 1000) / mhz);
	endfunction

	localparam logic [CNT_W-1:0] HF_SLOW_CYC = fpds_cyc(HF_SLOW_MHZ);
	localparam logic [CNT_W-1:0] HF_FAST_CYC = fpds_cyc(HF_FAST_MHZ);
	localparam logic [CNT_W-1:0] LF_CYC_TAB [8] = '{fpds_cyc(11_000), fpds_cyc(14_700), fpds_cyc(22_100),
		fpds_cyc(29_400), fpds_cyc(35_300), fpds_cyc(44_100), fpds_cyc(58_800), fpds_cyc(88_200)};
	localparam logic [CNT_W-1:0] STRETCH_CYC = CNT_W'((CLK_HZ * STRETCH_MIN_MS) / 1000);
	localparam logic [7:0] TACH_FILT_CYC = 8'((TACH_FILT_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

endpackage

// File: fpds_fan.sv
module fpds_fan #(
	parameter int HALF = 40
) (
	// Drive in, tach out.
	input wire logic clk,
	input wire logic pwm,
	output logic tach
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	logic lvl = 1'b1;
	//==================================================================
	// Rotor
	// The rotor turns only while driven, so tach holds its level when the drive is low.
	always @(posedge clk) begin
		if (pwm) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) begin
				lvl <= ~lvl;
			end
		end
	end
	// Each edge chatters for three cycles, as a slow tach edge does.
	assign tach = (cnt < 3 && pwm) ? (lvl ^ cnt[0]) : lvl;
endmodule

// File: fan_pwm_drive_stage_tb_top.sv
module fan_pwm_drive_stage_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [fpds_pkg::CNT_W-1:0] HS = 24'h28;
	localparam logic [fpds_pkg::CNT_W-1:0] ST = 24'h14;
	localparam logic [fpds_pkg::CNT_W-1:0] LFT [8] = '{24'hC8, 24'hB4, 24'hA0, 24'h8C, 24'h78, 24'h64, 24'h50, 24'h3C};
	logic clk = 1'b0;
	logic sys_rst, reg_wr, full_speed_en, full_speed_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [31:0] duty;
	logic [3:0] pwm_out, tach_level, tach_edge;
	wire logic [3:0] tach_in;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	fpds_drive #(.HF_SLOW_CYC(HS), .LF_CYC(LFT), .STRETCH_CYC(ST)) dut (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .duty(duty),
		.full_speed_en(full_speed_en), .full_speed_n(full_speed_n), .pwm_out(pwm_out), .tach_in(tach_in),
		.tach_level(tach_level), .tach_edge(tach_edge));
	fpds_fan u_fan[3:0] (.clk(clk), .pwm(pwm_out), .tach(tach_in));
	//==================================================================
	// Common tasks
	task automatic end_sim;
		if (miscompares == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		@(negedge clk);
		chk(reg_rdata, e);
	endtask
	task automatic wait_lvl(input int ch, input logic v);
		for (int i = 0; i < 3000 && pwm_out[ch] !== v; i++) @(negedge clk);
	endtask
	// Measures the high time and period of one full period of a channel.
	task automatic meas(input int ch, output int hi, output int per);
		@(negedge clk);
		wait_lvl(ch, 1'b0);
		wait_lvl(ch, 1'b1);
		wait_lvl(ch, 1'b0);
		wait_lvl(ch, 1'b1);
		hi = 0;
		while (pwm_out[ch] === 1'b1 && hi < 3000) begin
			@(negedge clk);
			hi++;
		end
		per = hi;
		while (pwm_out[ch] !== 1'b1 && per < 3000) begin
			@(negedge clk);
			per++;
		end
	endtask
	task automatic hold(input logic [3:0] v, input int n);
		int bad;
		bad = 0;
		repeat (n) begin
			@(negedge clk);
			if (pwm_out !== v) bad++;
		end
		chk(bad, 0);
	endtask
	//==================================================================
	// Scenarios
	task automatic sc_regs;
		logic [7:0] ad [5];
		logic [7:0] vd [5];
		ad = '{8'h40, 8'h68, 8'h69, 8'h74, 8'h50};
		vd = '{8'hA5, 8'h5A, 8'hC3, 8'h3C, 8'hFF};
		for (int i = 0; i < 4; i++) rd(ad[i], 8'h00);
		for (int i = 0; i < 5; i++) wr(ad[i], vd[i]);
		for (int i = 0; i < 5; i++) rd(ad[i], (i < 4) ? vd[i] : 8'h00);
	endtask
	task automatic sc_freq(input int lf, input int code, input logic [7:0] d);
		int p, o, hi, per;
		p = lf ? int'(LFT[code]) : ((code == 0) ? int'(HS) : int'(fpds_pkg::HF_FAST_CYC));
		o = (p * d) >> 8;
		if (lf && o < int'(ST)) o = (int'(ST) < p) ? int'(ST) : p;
		wr(8'h40, lf ? 8'h40 : 8'h00);
		wr(8'h74, {1'b0, 3'(code), 4'h0});
		duty <= {4{d}};
		meas(code % 4, hi, per);
		chk(per, p);
		chk(hi, o);
	endtask
	task automatic sc_inv;
		int hi, per;
		logic [3:0] m;
		wr(8'h40, 8'h00);
		wr(8'h74, 8'h00);
		duty <= {4{8'h40}};
		for (int r = 0; r < 2; r++) begin
			m = r ? 4'hA : 4'h5;
			wr(8'h68, r ? 8'h10 : 8'h20);
			wr(8'h69, r ? 8'h10 : 8'h20);
			for (int c = 0; c < 4; c++) begin
				meas(c, hi, per);
				chk(hi, m[c] ? 30 : 10);
			end
		end
	endtask
	task automatic sc_full;
		wr(8'h68, 8'h30);
		wr(8'h69, 8'h30);
		duty <= {4{8'hFF}};
		full_speed_n <= 1'b0;
		repeat (50) @(posedge clk);
		hold(4'h0, 100);
		@(posedge clk);
		full_speed_en <= 1'b1;
		repeat (4) @(posedge clk);
		hold(4'hF, 200);
		@(posedge clk);
		full_speed_n <= 1'b1;
		repeat (6) @(posedge clk);
		hold(4'h0, 100);
	endtask
	task automatic sc_tach;
		int c [4];
		int bad;
		c = '{0, 0, 0, 0};
		bad = 0;
		wr(8'h68, 8'h00);
		wr(8'h69, 8'h00);
		wr(8'h74, 8'h05);
		repeat (50) @(posedge clk);
		repeat (1000) begin
			@(negedge clk);
			for (int i = 0; i < 4; i++) c[i] += int'(tach_edge[i]);
			if ((tach_level & 4'h5) !== 4'h0) bad++;
		end
		chk(bad, 0);
		for (int i = 0; i < 4; i++) chk((i % 2 == 0) ? c[i] : int'(c[i] >= 12 && c[i] <= 13), i % 2);
	endtask
	//==================================================================
	// Main sequence and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 70000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		duty = 32'h0;
		full_speed_en = 1'b0;
		full_speed_n = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		sc_regs();
		wr(8'h68, 8'h00);
		wr(8'h69, 8'h00);
		for (int m = 0; m < 2; m++) for (int k = 0; k < 8; k++) sc_freq(m, k, 8'h80);
		sc_freq(0, 0, 8'h08);
		sc_freq(1, 0, 8'h08);
		sc_freq(1, 7, 8'h08);
		sc_inv();
		sc_full();
		sc_tach();
		end_sim();
	end
endmodule
